// *** core/rca_arbiter.sv ***
// local role arbitration unit of one redundant controller card
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`default_nettype none
// Overview of operation
// - only one card holds the active role
// - initialise and self-test before arbitrating
// - outgoing reset lines inactive before readiness
// - readiness only after passing self-test
// - forward own readiness to peer card
// - grant primary only to a ready card
// - primary grant comes with an interrupt
// - peer grant forwarded, interrupt on standby card
// - software reads the primary-grant bit
// - standby becomes active at once on failover
module rca_arbiter (
  // clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   rst_b_i,
  // avalon-mm slave
  input  wire logic [rca_pkg::AW-1:0] avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [rca_pkg::DW-1:0] avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic      [rca_pkg::DW-1:0] avs_readdata_o,
  output logic                        avs_waitrequest_o,
  // own card
  input  wire logic                   slot_id_i,
  input  wire logic                   reset_out_active_i,
  output logic                        primary_o,
  output logic                        standby_o,
  output logic                        irq_o,
  // peer card arbitration unit
  input  wire logic                   peer_present_i,
  input  wire logic                   peer_power_good_i,
  input  wire logic                   peer_ready_i,
  input  wire logic                   peer_primary_i,
  output logic                        ready_to_peer_o,
  output logic                        primary_to_peer_o
);
  import rca_pkg::*;

  logic rst_b; // synchronised reset

  rca_rst_sync u_rst (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .rst_b_o (rst_b)
  );

  // bus handshake state
  logic                ack;        // answer cycle marker
  logic                next_ack;
  logic                req;        // read or write pending
  logic                take;       // request completes this edge
  logic                wr_take;    // write takes effect
  logic [DW-1:0]       rdata;      // read data flop
  logic [DW-1:0]       next_rdata;
  logic [DW-1:0]       rd_mux;     // selected register

  // software registers
  logic [CTRL_W-1:0]   ctrl;
  logic [CTRL_W-1:0]   next_ctrl;
  logic [NUM_IRQ-1:0]  mask;
  logic [NUM_IRQ-1:0]  next_mask;
  logic [NUM_IRQ-1:0]  irq_clr;    // write-one-to-clear strobes
  logic [NUM_IRQ-1:0]  irq_set;    // hardware events
  logic [NUM_IRQ-1:0]  irq_flag;   // sticky flags
  logic [NUM_IRQ-1:0]  irq_pend;   // flags passing the mask

  // arbiter state
  rca_state_t          state;
  rca_state_t          next_state;
  logic [CNT_W-1:0]    init_cnt;   // power-up settle counter
  logic [CNT_W-1:0]    next_init_cnt;
  logic                ready_out;
  logic                next_ready_out;
  logic                primary;
  logic                next_primary;
  logic                peer_pri_q; // previous peer grant level
  logic                local_ok;   // card may become primary
  logic                peer_alive; // peer present, powered, ready
  logic                prefer;     // this slot wins a tie

  // bus request completes on the answer cycle
  assign req               = avs_read_i | avs_write_i;
  assign take              = req & ack;
  assign wr_take           = take & avs_write_i & avs_byteenable_i[0];
  assign avs_waitrequest_o = req & ~ack;
  assign avs_readdata_o    = rdata;

  // one wait state: ack rises after the request, drops after it
  always_comb begin
    next_ack = req & ~ack;
  end

  // register read mux; unmapped offsets read as zero
  always_comb begin
    rd_mux = '0;
    case (avs_address_i)
      OFS_CTRL: begin
        rd_mux[CTRL_W-1:0] = ctrl;
      end
      OFS_STATUS: begin
        rd_mux[STAT_PRIMARY]   = primary;
        rd_mux[STAT_STANDBY]   = state == s_standby;
        rd_mux[STAT_READY_OUT] = ready_out;
        rd_mux[STAT_PEER_RDY]  = peer_ready_i;
        rd_mux[STAT_PEER_PRI]  = peer_primary_i;
        rd_mux[STAT_RST_BUSY]  = reset_out_active_i;
        rd_mux[STAT_STATE_LSB +: 3] = state;
      end
      OFS_IRQ_STAT: begin
        rd_mux[NUM_IRQ-1:0] = irq_flag;
      end
      OFS_IRQ_MASK: begin
        rd_mux[NUM_IRQ-1:0] = mask;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // read data captured as waitrequest drops, held until next read
  always_comb begin
    next_rdata = rdata;
    if (avs_read_i && !ack) begin
      next_rdata = rd_mux;
    end
  end

  // software writes land on the completing edge, lane zero only
  always_comb begin
    next_ctrl = ctrl;
    next_mask = mask;
    irq_clr   = '0;
    if (wr_take) begin
      case (avs_address_i)
        OFS_CTRL: begin
          next_ctrl = avs_writedata_i[CTRL_W-1:0];
        end
        OFS_IRQ_MASK: begin
          next_mask = avs_writedata_i[NUM_IRQ-1:0];
        end
        OFS_IRQ_STAT: begin
          irq_clr = avs_writedata_i[NUM_IRQ-1:0];
        end
        default: begin
          next_ctrl = ctrl; // writes elsewhere ignored
        end
      endcase
    end
  end

  // bus and software register flops
  always_ff @(posedge clock_i or negedge rst_b) begin
    if (!rst_b) begin
      ack   <= 1'b0;
      rdata <= '0;
      ctrl  <= CTRL_RESET;
      mask  <= MASK_RESET;
    end else begin
      ack   <= next_ack;
      rdata <= next_rdata;
      ctrl  <= next_ctrl;
      mask  <= next_mask;
    end
  end

  // readiness needs a passed test and quiet reset lines
  assign local_ok   = ctrl[CTRL_TEST_PASS] & ctrl[CTRL_WANT_PRI]
                    & ~reset_out_active_i;
  // removal, power loss or withdrawn readiness all mean gone
  assign peer_alive = peer_present_i & peer_power_good_i & peer_ready_i;
  // fixed preference keeps a tie deterministic
  assign prefer     = ~slot_id_i;

  // role state machine
  always_comb begin
    next_state    = state;
    next_init_cnt = init_cnt;
    case (state)
      s_init: begin
        // give on-board parts time to come out of power-up
        if (init_cnt == CNT_W'(INIT_CYCLES - 1)) begin
          next_state = s_selftest;
        end else begin
          next_init_cnt = init_cnt + 1'b1;
        end
      end
      s_selftest: begin
        // software reports the self-test is finished
        if (ctrl[CTRL_TEST_DONE]) begin
          next_state = s_wait_ready;
        end
      end
      s_wait_ready: begin
        if (local_ok) begin
          next_state = s_settle;
        end
      end
      s_settle: begin
        // one cycle lets the peer see our ready before we decide
        if (!local_ok) begin
          next_state = s_wait_ready;
        end else if (peer_alive && peer_primary_i) begin
          next_state = s_standby;
        end else if (!peer_alive || prefer) begin
          next_state = s_primary;
        end else begin
          next_state = s_standby;
        end
      end
      s_primary: begin
        if (!local_ok) begin
          next_state = s_wait_ready;
        end else if (peer_alive && peer_primary_i && !prefer) begin
          // rare collision: the non-preferred slot backs off
          next_state = s_standby;
        end
      end
      s_standby: begin
        if (!local_ok) begin
          next_state = s_wait_ready;
        end else if (!peer_alive) begin
          next_state = s_primary;
        end
      end
      default: begin
        next_state = s_init;
      end
    endcase
  end

  // outputs follow the next state so they move with it
  always_comb begin
    next_primary   = next_state == s_primary;
    next_ready_out = local_ok && (next_state == s_settle
                   || next_state == s_primary
                   || next_state == s_standby);
  end

  // arbiter flops
  always_ff @(posedge clock_i or negedge rst_b) begin
    if (!rst_b) begin
      state      <= s_init;
      init_cnt   <= '0;
      primary    <= 1'b0;
      ready_out  <= 1'b0;
      peer_pri_q <= 1'b0;
    end else begin
      state      <= next_state;
      init_cnt   <= next_init_cnt;
      primary    <= next_primary;
      ready_out  <= next_ready_out;
      peer_pri_q <= peer_primary_i;
    end
  end

  assign primary_o         = primary;
  assign standby_o         = state == s_standby;
  assign ready_to_peer_o   = ready_out;
  assign primary_to_peer_o = primary;

  // interrupt events, own role flags set on the same edge as the role change, peer grant on the edge after peer_primary_i rises
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_GRANT]      = next_primary & ~primary;
    irq_set[IRQ_PEER_GRANT] = peer_primary_i & ~peer_pri_q
                            & ~primary;
    irq_set[IRQ_FAILOVER]   = (state == s_standby)
                            & (next_state == s_primary);
    irq_set[IRQ_READY_LOST] = (state != s_wait_ready)
                            & (next_state == s_wait_ready);
  end

  // one sticky flag per event
  for (genvar i = 0; i < NUM_IRQ; i++) begin : g_irq
    rca_irq_bit u_bit (
      .clock_i (clock_i),
      .rst_b_i (rst_b),
      .set_i   (irq_set[i]),
      .clear_i (irq_clr[i]),
      .mask_i  (mask[i]),
      .flag_o  (irq_flag[i]),
      .pend_o  (irq_pend[i])
    );
  end

  // level interrupt while any unmasked flag is set
  assign irq_o = |irq_pend;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b);

  one_active_a: assert property (
    primary && peer_primary_i && peer_alive && !prefer |=> !primary)
    else $error("both cards kept the active role");
  selftest_gate_a: assert property (
    (state == s_init || state == s_selftest) |-> !primary && !ready_out)
    else $error("role taken before self-test finished");
  reset_lines_a: assert property (
    reset_out_active_i |=> !ready_out)
    else $error("ready with outgoing reset lines active");
  ready_cause_a: assert property (
    ready_out |-> $past(ctrl[CTRL_TEST_PASS] && ctrl[CTRL_WANT_PRI]))
    else $error("ready without a passed self-test");
  ready_fwd_a: assert property (
    state == s_wait_ready && local_ok |=> ready_to_peer_o ##1 1'b1)
    else $error("readiness not forwarded to peer");
  grant_ready_a: assert property (
    $rose(primary) |-> $past(local_ok) && $past(state == s_settle
      || state == s_standby))
    else $error("primary granted to a card not ready");
  grant_irq_a: assert property (
    $rose(primary) |-> irq_flag[IRQ_GRANT])
    else $error("grant without interrupt");
  peer_irq_a: assert property (
    $rose(peer_primary_i) && !primary |=> irq_flag[IRQ_PEER_GRANT])
    else $error("peer grant without interrupt");
  status_read_a: assert property (
    avs_read_i && !ack && avs_address_i == OFS_STATUS
      |=> avs_readdata_o[STAT_PRIMARY] == $past(primary))
    else $error("status read shows wrong primary bit");
  failover_a: assert property (
    state == s_standby && local_ok && !peer_alive
      |=> primary && irq_flag[IRQ_FAILOVER])
    else $error("standby did not take over at once");
  hold_grant_a: assert property (
    primary && local_ok && !(peer_alive && peer_primary_i && !prefer)
      |=> primary)
    else $error("grant dropped without cause");

  grant_c:    cover property ($rose(primary) && !peer_alive);
  tie_c:      cover property (state == s_settle && peer_alive && prefer);
  failover_c: cover property (irq_set[IRQ_FAILOVER]);
  clr_race_c: cover property (irq_set[IRQ_GRANT] && irq_clr[IRQ_GRANT]);
endmodule
`default_nettype wire

// *** core/rca_irq_bit.sv ***
// one sticky interrupt flag with write-one-to-clear and mask
`default_nettype none
module rca_irq_bit (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  // event, clear and mask
  input  wire logic set_i,
  input  wire logic clear_i,
  input  wire logic mask_i,
  // flag and gated request
  output logic      flag_o,
  output logic      pend_o
);
  logic flag;      // sticky state
  logic next_flag; // next value

  // set beats clear so an event in the clear cycle is kept
  always_comb begin
    next_flag = flag;
    if (clear_i) begin
      next_flag = 1'b0;
    end
    if (set_i) begin
      next_flag = 1'b1;
    end
  end

  // register only
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  assign flag_o = flag;
  assign pend_o = flag & mask_i;
endmodule
`default_nettype wire

// *** core/rca_pkg.sv ***
// package: constants, register map and states of the role arbiter
`default_nettype none
package rca_pkg;
  // clock and power-up settle time
  localparam int CLK_PERIOD_NS = 40;
  localparam int INIT_TIME_NS  = 1000;
  localparam int INIT_CYCLES   =
    (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;
  // bus geometry
  localparam int AW = 4;
  localparam int DW = 32;
  // register byte offsets
  localparam logic [AW-1:0] OFS_CTRL     = 4'h0;
  localparam logic [AW-1:0] OFS_STATUS   = 4'h4;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 4'hc;
  // control fields
  localparam int CTRL_TEST_DONE = 0;
  localparam int CTRL_TEST_PASS = 1;
  localparam int CTRL_WANT_PRI  = 2;
  localparam int CTRL_W         = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  // status fields
  localparam int STAT_PRIMARY   = 0;
  localparam int STAT_STANDBY   = 1;
  localparam int STAT_READY_OUT = 2;
  localparam int STAT_PEER_RDY  = 3;
  localparam int STAT_PEER_PRI  = 4;
  localparam int STAT_RST_BUSY  = 5;
  localparam int STAT_STATE_LSB = 8;
  // interrupt bits, same layout in status and mask
  localparam int IRQ_GRANT      = 0;
  localparam int IRQ_PEER_GRANT = 1;
  localparam int IRQ_FAILOVER   = 2;
  localparam int IRQ_READY_LOST = 3;
  localparam int NUM_IRQ        = 4;
  localparam logic [NUM_IRQ-1:0] MASK_RESET = 4'h0;
  // arbiter states
  typedef enum logic [2:0] {
    s_init, s_selftest, s_wait_ready, s_settle, s_primary, s_standby
  } rca_state_t;
endpackage
`default_nettype wire

// *** core/rca_rst_sync.sv ***
// reset release synchroniser: async assert, two-flop release
`default_nettype none
module rca_rst_sync (
  // clock and raw reset
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  // synchronised reset
  output logic      rst_b_o
);
  logic meta; // first stage, read only by the second
  logic sync; // second stage

  // both stages clear at once, release ripples through
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
    end else begin
      meta <= 1'b1;
      sync <= meta;
    end
  end

  assign rst_b_o = sync;
endmodule
`default_nettype wire

// *** verification/rca_peer_model.sv ***
// behavioural model of the peer card arbitration unit
`default_nettype none
module rca_peer_model (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  // bench controls: plugged in, powered, ready, wants the role
  input  wire logic plug_i,
  input  wire logic power_i,
  input  wire logic ready_i,
  input  wire logic want_i,
  // role of the card under test
  input  wire logic dut_primary_i,
  // backplane lines, pulled down when the card is gone
  output logic      present_o,
  output logic      power_good_o,
  output logic      ready_o,
  output logic      primary_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic claim;  // peer holds the role
  // a pulled card leaves every line low; a dead supply leaves all but present_o low
  assign present_o    = plug_i;
  assign power_good_o = plug_i & power_i;
  // readiness only after its own tests, passed to our unit
  assign ready_o      = power_good_o & ready_i;
  // role dropped at once with readiness
  assign primary_o    = claim & ready_o;
  // claims only while the other card does not hold the role
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      claim <= 1'b0;
    end else begin
      claim <= ready_o & want_i & ~dut_primary_i;
    end
  end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench: role arbiter against a modelled peer card
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rca_pkg::*;
  // clock, reset and bus
  logic          clock_i, rst_b_i, rd, wr, waitreq;
  logic [AW-1:0] address;
  logic [DW-1:0] wdata, rdata;
  // own card and peer lines
  logic          slot_id, rst_out, primary, standby, irq;
  logic          p_present, p_pgood, p_ready_l, p_primary;
  logic          to_peer_rdy, to_peer_pri;
  // peer model controls
  logic          plug, power, p_ready, p_want;
  // bookkeeping
  int            bad_count, n_compared, cyc;

  rca_arbiter dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .avs_address_i(address), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .slot_id_i(slot_id), .reset_out_active_i(rst_out),
    .primary_o(primary), .standby_o(standby), .irq_o(irq),
    .peer_present_i(p_present), .peer_power_good_i(p_pgood),
    .peer_ready_i(p_ready_l), .peer_primary_i(p_primary),
    .ready_to_peer_o(to_peer_rdy), .primary_to_peer_o(to_peer_pri));

  rca_peer_model peer (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .plug_i(plug), .power_i(power), .ready_i(p_ready), .want_i(p_want),
    .dut_primary_i(to_peer_pri), .present_o(p_present),
    .power_good_o(p_pgood), .ready_o(p_ready_l), .primary_o(p_primary));

  // 25 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // hang guard, far above the few hundred cycles needed
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      finish_test();
    end
  end

  // verdict and end of run
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // compare one flag
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %b got %b", nm, e, g);
    end
  endtask

  // compare one register word
  task automatic chk_word(input string nm, input logic [DW-1:0] e,
                          input logic [DW-1:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  // one bus transfer: request held up to the edge that sees
  // waitrequest low; data taken at that edge, only then released
  task automatic bus_xfer(input logic w, input logic [AW-1:0] a,
                          input logic [DW-1:0] d, output logic [DW-1:0] q);
    int   n;
    logic done;
    n = 0;
    q = '0;
    @(posedge clock_i);
    address <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clock_i);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    done = (waitreq === 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    chk_bit("bus answer", 1'b1, done);
  endtask

  task automatic bus_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic [DW-1:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask

  task automatic bus_rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] e,
                            input string nm);
    logic [DW-1:0] q;
    bus_xfer(1'b0, a, '0, q);
    chk_word(nm, e, q);
  endtask

  // n edges, then look in the settled middle of the cycle
  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask

  // give the role away to the peer and come back as standby
  task automatic go_standby();
    bus_wr(OFS_CTRL, 32'h0);
    settle(3);
    bus_wr(OFS_CTRL, 32'h7);
    settle(3);
    chk_bit("standby", 1'b1, standby);
    bus_wr(OFS_IRQ_STAT, 32'hf);
  endtask

  // main sequence
  initial begin
    rst_b_i = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    address = '0;
    wdata = '0;
    slot_id = 1'b0;
    rst_out = 1'b0;
    plug = 1'b1;
    power = 1'b1;
    p_ready = 1'b0;
    p_want = 1'b0;
    bad_count = 0;
    n_compared = 0;
    cyc = 0;
    repeat (12) @(posedge clock_i);
    rst_b_i <= 1'b1;
    settle(3);
    // status first, while still in power-up settle
    bus_rd_chk(OFS_STATUS, 32'h0, "status init");
    bus_rd_chk(OFS_CTRL, 32'h0, "ctrl reset");
    bus_rd_chk(OFS_IRQ_MASK, 32'h0, "mask reset");
    bus_rd_chk(4'h2, 32'h0, "unmapped");
    $display("test reset_values done");
    settle(30);
    bus_wr(OFS_CTRL, 32'h6);
    settle(4);
    chk_bit("ready untested", 1'b0, to_peer_rdy);
    bus_rd_chk(OFS_STATUS, 32'h100, "status selftest");
    @(posedge clock_i);
    rst_out <= 1'b1;
    bus_wr(OFS_CTRL, 32'h7);
    settle(4);
    chk_bit("ready rst busy", 1'b0, to_peer_rdy);
    chk_bit("primary unready", 1'b0, primary);
    @(posedge clock_i);
    rst_out <= 1'b0;
    settle(3);
    chk_bit("ready out", 1'b1, to_peer_rdy);
    chk_bit("primary", 1'b1, primary);
    chk_bit("primary to peer", 1'b1, to_peer_pri);
    chk_bit("irq masked", 1'b0, irq);
    bus_wr(OFS_IRQ_MASK, 32'hf);
    settle(1);
    chk_bit("irq grant", 1'b1, irq);
    bus_rd_chk(OFS_STATUS, 32'h405, "status primary");
    // leaving self-test also counts as entering wait_ready
    bus_rd_chk(OFS_IRQ_STAT, 32'h9, "grant flag");
    bus_wr(OFS_IRQ_STAT, 32'hf);
    settle(1);
    chk_bit("irq cleared", 1'b0, irq);
    $display("test first_grant done");
    // peer turns up wanting the role: ours is kept
    @(posedge clock_i);
    p_ready <= 1'b1;
    p_want <= 1'b1;
    settle(20);
    chk_bit("grant held", 1'b1, primary);
    bus_wr(OFS_CTRL, 32'h3);
    settle(3);
    chk_bit("ready withdrawn", 1'b0, to_peer_rdy);
    chk_bit("primary dropped", 1'b0, primary);
    bus_wr(OFS_CTRL, 32'h7);
    settle(3);
    chk_bit("standby", 1'b1, standby);
    chk_bit("not primary", 1'b0, primary);
    bus_rd_chk(OFS_IRQ_STAT, 32'ha, "peer grant flag");
    bus_wr(OFS_IRQ_STAT, 32'hf);
    $display("test peer_grant done");
    // removal, power loss and withdrawal of the primary peer
    for (int k = 0; k < 3; k++) begin
      @(posedge clock_i);
      if (k == 0) begin
        plug <= 1'b0;
      end else if (k == 1) begin
        power <= 1'b0;
      end else begin
        p_ready <= 1'b0;
      end
      settle(2);
      chk_bit("failover", 1'b1, primary);
      chk_bit("irq failover", 1'b1, irq);
      bus_rd_chk(OFS_IRQ_STAT, 32'h5, "failover flags");
      @(posedge clock_i);
      plug <= 1'b1;
      power <= 1'b1;
      p_ready <= 1'b1;
      go_standby();
    end
    $display("test failover done");
    // peer ready but not claiming: slot decides the role
    @(posedge clock_i);
    p_want <= 1'b0;
    for (int s = 1; s >= 0; s--) begin
      @(posedge clock_i);
      slot_id <= s[0];
      bus_wr(OFS_CTRL, 32'h0);
      settle(3);
      bus_wr(OFS_CTRL, 32'h7);
      settle(3);
      chk_bit("slot preference", ~s[0], primary);
    end
    $display("test slot_preference done");
    finish_test();
  end
endmodule
`default_nettype wire
